// ===== agd_host_model.sv
// host side sink for the dma stream, with optional back-pressure
`timescale 1ns/1ps
module agd_host_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [31:0] dmaData,
	input wire logic dmaValid,
	input wire logic dmaLast,
	output logic dmaReady
);
	logic [31:0] words[$]; // accepted words in order
	logic lasts[$]; // end marker of each accepted word
	// accept a word on valid and ready; slow drops ready every other cycle
	// plain always: the bench empties the queues between scenarios
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dmaReady <= 1'b0;
		end else begin
			dmaReady <= slow ? !dmaReady : 1'b1;
			if (dmaValid && dmaReady) begin
				words.push_back(dmaData);
				lasts.push_back(dmaLast);
			end
		end
	end
endmodule : agd_host_model

// ===== agd_pkg.sv
// constants, state codes and state record of the acquisition gate dma block
package agd_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses on the apb bus)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_CTRL = 12'h000; // control bits
	localparam logic [11:0] OFF_SRC = 12'h004; // input select per module
	localparam logic [11:0] OFF_STATUS = 12'h008; // engine state
	localparam logic [11:0] OFF_TSTAMP = 12'h00c; // sample time stamp
	localparam logic [11:0] OFF_LINK0 = 12'h020; // first link definition
	localparam int NUM_LINKS = 4;
	localparam logic [11:0] LINK_SPAN = 12'h010; // bytes of link table

	// control register fields
	localparam int CTRL_START = 0; // write one: run the link list
	localparam int CTRL_TRANSIENT = 1; // one: transient capture on gate
	localparam int CTRL_VCXO = 2; // one: oscillator clock, zero: direct
	localparam int CTRL_MASTER = 3; // one: drive the timing bus
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h0e; // start is not stored

	// input select codes, two bits per module
	localparam int SRC_W = 2;
	localparam logic [1:0] SRC_ADC0 = 2'h0;
	localparam logic [1:0] SRC_ADC1 = 2'h1;
	localparam logic [1:0] SRC_TEST = 2'h2;
	localparam logic [3:0] SRC_RST = 4'h4; // module 0 adc0, module 1 adc1

	// link definition fields
	localparam int LK_LEN_LSB = 0;
	localparam int LK_LEN_W = 16;
	localparam int LK_NEXT_LSB = 16;
	localparam int LK_GATE = 18; // gate driven length
	localparam int LK_META = 19; // emit metadata packet
	localparam int LK_END = 20; // last link of the chain
	localparam int LK_MOD = 21; // acquisition module 0 or 1
	localparam int LINK_W = 22;
	localparam logic [21:0] LINK_RST = 22'h100000; // end of chain

	// samples and memory banks
	localparam int SAMPLE_W = 16;
	localparam int BANK_DEPTH = 256; // words held per bank
	localparam int BANK_AW = 8;
	localparam logic [31:0] SRAM_MAX_BYTES = 32'h0080_0000; // 8 MB
	localparam logic [31:0] DDR_MAX_BYTES = 32'h2000_0000; // 512 MB
	localparam logic [1:0] BANK_ID0 = 2'h1; // module 0 uses bank 1
	localparam logic [1:0] BANK_ID1 = 2'h2; // module 1 uses bank 2

	// engine states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ARM = 6'h02,
		ST_ACQ = 6'h04,
		ST_META = 6'h08,
		ST_DATA = 6'h10,
		ST_NEXT = 6'h20
	} agd_state_e;

	// whole state of the block except the bank memory
	typedef struct packed {
		agd_state_e st;
		logic [1:0] link;
		logic mod;
		logic gateSeen;
		logic [15:0] wrCnt;
		logic [15:0] rdCnt;
		logic metaIdx;
		logic [31:0] tstamp;
		logic [31:0] tsFirst;
		logic [7:0] ctrl;
		logic [3:0] src;
		logic [3:0][21:0] links;
		logic [15:0] lastLen;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic dmaValid;
		logic dmaLast;
		logic [31:0] dmaData;
		logic busClkOut;
		logic [1:0] busSyncOut;
		logic [1:0] busGateOut;
		logic busOe;
		logic vcxoSel;
		logic prevBusClk;
		logic [15:0] testRamp;
	} agd_state_s;

endpackage : agd_pkg

// ===== agd_top.sv
// two-module acquisition path with gate driven linked-list dma engine
`timescale 1ns/1ps

// Function
// - each module picks adc0, adc1 or test signal
// - accept sixteen bit converter sample words
// - each module owns a bank, fifo or transient
// - dma walks a linked list of transfers
// - gate mode: length equals gated sample count
// - optional metadata: channel, time stamp, length
// - direct mode uses external clock as sample clock
// - vcxo mode locks oscillator to ten megahertz
// - timing bus: one clock, two sync, two gate
// - slave mode takes timing from the bus
// - master mode drives timing onto the bus
// - modules use banks one and two
// - banks sized up to 8 MB or 512 MB
// - timing generator supplies all gate and sync
module agd_top (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] adc0Data,
	input wire logic [15:0] adc1Data,
	input wire logic adcValid,
	input wire logic [1:0] gateIn,
	input wire logic [1:0] syncIn,
	input wire logic busClkIn,
	input wire logic [1:0] busSyncIn,
	input wire logic [1:0] busGateIn,
	output logic busClkOut,
	output logic [1:0] busSyncOut,
	output logic [1:0] busGateOut,
	output logic busOe,
	output logic vcxoSel,
	output logic [31:0] dmaData,
	output logic dmaValid,
	output logic dmaLast,
	input wire logic dmaReady
);

	// ---------------------------------------------------------------
	// helper functions
	// ---------------------------------------------------------------

	// input stream multiplexer of one acquisition module
	function automatic logic [15:0] pickSample(
		input logic [1:0] sel,
		input logic [15:0] a0,
		input logic [15:0] a1,
		input logic [15:0] tst
	);
		case (sel)
			agd_pkg::SRC_ADC0: pickSample = a0;
			agd_pkg::SRC_ADC1: pickSample = a1;
			agd_pkg::SRC_TEST: pickSample = tst;
			default: pickSample = 16'h0000;
		endcase
	endfunction : pickSample

	// true when the address falls inside the link table
	function automatic logic isLink(input logic [11:0] a);
		isLink = (a >= agd_pkg::OFF_LINK0) &&
			(a < agd_pkg::OFF_LINK0 + agd_pkg::LINK_SPAN);
	endfunction : isLink

	// link table index of an address
	function automatic logic [1:0] linkIdx(input logic [11:0] a);
		logic [11:0] d;
		d = a - agd_pkg::OFF_LINK0;
		linkIdx = d[3:2];
	endfunction : linkIdx

	// ---------------------------------------------------------------
	// state, memory and timing signals
	// ---------------------------------------------------------------
	agd_pkg::agd_state_s r; // registered state
	agd_pkg::agd_state_s next_r; // next state
	logic [15:0] bankMem [2][agd_pkg::BANK_DEPTH]; // banks 1 and 2
	logic tick; // one sample period has passed
	logic [1:0] intGate; // gate signals used inside
	logic [1:0] intSync; // sync signals used inside
	logic master; // this board drives the bus
	logic [21:0] curLink; // link definition in flight
	logic [15:0] sample; // sample of the active module
	logic gateNow; // gate of the active module
	logic capture; // write a sample this cycle
	logic full; // bank of the active module is full
	logic acqDone; // the link's acquisition has ended
	logic slotFree; // dma output register may be loaded
	logic [31:0] metaWord0; // channel and length word

	// ---------------------------------------------------------------
	// timing generator
	// ---------------------------------------------------------------

	// master takes local gate and sync, slave takes the bus
	always_comb begin
		master = r.ctrl[agd_pkg::CTRL_MASTER];
		intGate = master ? gateIn : busGateIn;
		intSync = master ? syncIn : busSyncIn;
		// sample period: converter strobe, or a bus clock rise
		tick = master ? adcValid : (busClkIn && !r.prevBusClk);
	end

	// ---------------------------------------------------------------
	// acquisition datapath
	// ---------------------------------------------------------------

	// active link and the sample stream of its module
	always_comb begin
		curLink = r.links[r.link];
		sample = pickSample(r.src[r.mod * agd_pkg::SRC_W +: agd_pkg::SRC_W],
			adc0Data, adc1Data, r.testRamp);
		gateNow = intGate[r.mod];
		// banks hold fewer words than either memory type allows
		full = (r.wrCnt >= 16'(agd_pkg::BANK_DEPTH));
		capture = (r.st == agd_pkg::ST_ACQ) && r.gateSeen && tick &&
			!full && (!curLink[agd_pkg::LK_GATE] || gateNow);
		if (curLink[agd_pkg::LK_GATE]) begin
			// gate driven: the gate falling ends the transfer
			acqDone = r.gateSeen && (!gateNow || full);
		end else begin
			acqDone = r.gateSeen && (full || r.wrCnt ==
				curLink[agd_pkg::LK_LEN_LSB +: agd_pkg::LK_LEN_W]);
		end
		slotFree = !r.dmaValid || dmaReady;
		// channel word: bank, source, length actually captured
		metaWord0 = {12'h000, (r.mod ? agd_pkg::BANK_ID1 :
			agd_pkg::BANK_ID0), r.src[r.mod * agd_pkg::SRC_W +:
			agd_pkg::SRC_W], r.lastLen};
	end

	// bank write port, no reset on the storage itself
	always_ff @(posedge core_clk) begin
		if (capture) begin
			bankMem[r.mod][r.wrCnt[agd_pkg::BANK_AW-1:0]] <= sample;
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.prevBusClk = busClkIn;

		// free running test pattern and time stamp
		if (tick) begin
			next_r.testRamp = r.testRamp + 16'h0001;
		end
		if (intSync[0]) begin
			next_r.tstamp = 32'h0000_0000; // sync zeroes the time base
		end else if (tick) begin
			next_r.tstamp = r.tstamp + 32'h0000_0001;
		end
		if (intSync[1]) begin
			next_r.testRamp = 16'h0000; // second sync aligns the pattern
		end

		// timing bus drive in master mode
		next_r.busOe = master;
		next_r.busClkOut = master && tick;
		next_r.busSyncOut = master ? syncIn : 2'h0;
		next_r.busGateOut = master ? gateIn : 2'h0;
		next_r.vcxoSel = r.ctrl[agd_pkg::CTRL_VCXO];

		// apb: setup cycle prepares the answer
		if (psel && !penable) begin
			next_r.pready = 1'b1;
			next_r.pslverr = 1'b0;
			next_r.prdata = 32'h0000_0000;
			if (paddr == agd_pkg::OFF_CTRL) begin
				next_r.prdata = {24'h000000, r.ctrl};
			end else if (paddr == agd_pkg::OFF_SRC) begin
				next_r.prdata = {28'h0000000, r.src};
			end else if (paddr == agd_pkg::OFF_STATUS) begin
				next_r.prdata = {r.lastLen, 6'h00, r.link, 2'h0, r.st};
			end else if (paddr == agd_pkg::OFF_TSTAMP) begin
				next_r.prdata = r.tstamp;
			end else if (isLink(paddr)) begin
				next_r.prdata = {10'h000, r.links[linkIdx(paddr)]};
			end else begin
				next_r.pslverr = 1'b1; // unmapped address
			end
		end else if (psel && penable && r.pready) begin
			// access cycle: the write lands at this edge
			next_r.pready = 1'b0;
			next_r.pslverr = 1'b0;
			if (pwrite) begin
				if (paddr == agd_pkg::OFF_CTRL) begin
					next_r.ctrl = pwdata[7:0] & agd_pkg::CTRL_WMASK;
				end else if (paddr == agd_pkg::OFF_SRC) begin
					next_r.src = pwdata[3:0];
				end else if (isLink(paddr)) begin
					next_r.links[linkIdx(paddr)] = pwdata[21:0];
				end
			end
		end else begin
			next_r.pready = 1'b0;
			next_r.pslverr = 1'b0;
		end

		// dma output register empties when taken
		if (r.dmaValid && dmaReady) begin
			next_r.dmaValid = 1'b0;
			next_r.dmaLast = 1'b0;
		end

		// linked-list engine
		case (r.st)
			agd_pkg::ST_IDLE: begin
				if (psel && penable && r.pready && pwrite &&
					paddr == agd_pkg::OFF_CTRL &&
					pwdata[agd_pkg::CTRL_START]) begin
					next_r.link = 2'h0;
					next_r.st = agd_pkg::ST_ARM;
				end
			end
			agd_pkg::ST_ARM: begin
				// fresh link: empty bank, a fixed-length link in fifo mode starts at once
				next_r.mod = curLink[agd_pkg::LK_MOD];
				next_r.wrCnt = 16'h0000;
				next_r.rdCnt = 16'h0000;
				next_r.metaIdx = 1'b0;
				next_r.gateSeen = !curLink[agd_pkg::LK_GATE] &&
					!r.ctrl[agd_pkg::CTRL_TRANSIENT];
				next_r.st = agd_pkg::ST_ACQ;
			end
			agd_pkg::ST_ACQ: begin
				if (!r.gateSeen) begin
					// wait for the gate or trigger to open
					if (gateNow) begin
						next_r.gateSeen = 1'b1;
					end
				end else if (acqDone) begin
					// close the link with its real length
					next_r.lastLen = r.wrCnt;
					if (curLink[agd_pkg::LK_META]) begin
						next_r.st = agd_pkg::ST_META;
					end else if (r.wrCnt == 16'h0000) begin
						next_r.st = agd_pkg::ST_NEXT;
					end else begin
						next_r.st = agd_pkg::ST_DATA;
					end
				end else if (capture) begin
					if (r.wrCnt == 16'h0000) begin
						next_r.tsFirst = r.tstamp; // stamp of first sample
					end
					next_r.wrCnt = r.wrCnt + 16'h0001;
				end
			end
			agd_pkg::ST_META: begin
				// two words: channel and length, then time stamp
				if (slotFree) begin
					next_r.dmaValid = 1'b1;
					next_r.dmaLast = 1'b0;
					if (!r.metaIdx) begin
						next_r.dmaData = metaWord0;
						next_r.metaIdx = 1'b1;
					end else begin
						next_r.dmaData = r.tsFirst;
						if (r.lastLen == 16'h0000) begin
							next_r.dmaLast = 1'b1;
							next_r.st = agd_pkg::ST_NEXT;
						end else begin
							next_r.st = agd_pkg::ST_DATA;
						end
					end
				end
			end
			agd_pkg::ST_DATA: begin
				// drain the bank toward the host, one sample a word
				if (slotFree) begin
					next_r.dmaValid = 1'b1;
					next_r.dmaData = {16'h0000,
						bankMem[r.mod][r.rdCnt[agd_pkg::BANK_AW-1:0]]};
					next_r.rdCnt = r.rdCnt + 16'h0001;
					if (r.rdCnt + 16'h0001 == r.lastLen) begin
						next_r.dmaLast = 1'b1;
						next_r.st = agd_pkg::ST_NEXT;
					end else begin
						next_r.dmaLast = 1'b0;
					end
				end
			end
			agd_pkg::ST_NEXT: begin
				// follow the chain or stop at its end
				if (curLink[agd_pkg::LK_END]) begin
					next_r.st = agd_pkg::ST_IDLE;
				end else begin
					next_r.link = curLink[agd_pkg::LK_NEXT_LSB +: 2];
					next_r.st = agd_pkg::ST_ARM;
				end
			end
			default: begin
				next_r.st = agd_pkg::ST_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= agd_pkg::ST_IDLE;
			r.ctrl <= agd_pkg::CTRL_RST;
			r.src <= agd_pkg::SRC_RST;
			r.links <= {agd_pkg::NUM_LINKS{agd_pkg::LINK_RST}};
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// outputs straight from the state register
	// ---------------------------------------------------------------
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign busClkOut = r.busClkOut;
	assign busSyncOut = r.busSyncOut;
	assign busGateOut = r.busGateOut;
	assign busOe = r.busOe;
	assign vcxoSel = r.vcxoSel;
	assign dmaData = r.dmaData;
	assign dmaValid = r.dmaValid;
	assign dmaLast = r.dmaLast;

endmodule : agd_top

// ===== agd_top_assertions.sv
// concurrent checks on the ports of the acquisition gate dma top level
`timescale 1ns/1ps
module agd_top_assertions (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic adcValid,
	input wire logic [1:0] gateIn,
	input wire logic [1:0] syncIn,
	input wire logic busClkOut,
	input wire logic [1:0] busSyncOut,
	input wire logic [1:0] busGateOut,
	input wire logic busOe,
	input wire logic [31:0] dmaData,
	input wire logic dmaValid,
	input wire logic dmaLast,
	input wire logic dmaReady
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// setup cycle followed by access cycle
	sequence apb_access;
		psel && !penable ##1 psel && penable;
	endsequence
	a_apb_zero_wait: assert property (apb_access |-> pready)
		else $error("pready missing in access cycle");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_refused_read: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	a_dma_held: assert property (dmaValid && !dmaReady |=>
		dmaValid && $stable(dmaData) && $stable(dmaLast))
		else $error("stream word changed before taken");
	a_last_valid: assert property (dmaLast |-> dmaValid)
		else $error("last without valid");
	a_bus_quiet: assert property (!busOe |-> !busClkOut &&
		busSyncOut == 2'h0 && busGateOut == 2'h0)
		else $error("bus driven in slave mode");
	a_bus_copy: assert property (busOe && $past(busOe) |->
		busSyncOut == $past(syncIn) && busGateOut == $past(gateIn))
		else $error("bus sync or gate not copied");
	a_tick_out: assert property (busClkOut |-> $past(adcValid))
		else $error("bus clock pulse without tick");
	a_tick_echo: assert property (busOe && $past(busOe) &&
		$past(adcValid) |-> busClkOut)
		else $error("tick not driven onto bus");
endmodule : agd_top_assertions

bind agd_top agd_top_assertions u_agd_top_assertions (.core_clk, .rst_n,
	.psel, .penable, .prdata, .pready, .pslverr, .adcValid, .gateIn, .syncIn,
	.busClkOut, .busSyncOut, .busGateOut, .busOe, .dmaData, .dmaValid,
	.dmaLast, .dmaReady);

// ===== agd_top_test.sv
// self-checking testbench for the acquisition gate dma top level
`timescale 1ns/1ps
module agd_top_test;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, dmaData, rdata;
	logic [15:0] adc0Data, adc1Data;
	logic [1:0] gateIn, syncIn, busSyncIn, busGateIn, busSyncOut, busGateOut;
	logic adcValid, busClkIn, busClkOut, busOe, vcxoSel, dmaValid, dmaLast;
	logic dmaReady, slow, master, rerr;
	logic [31:0] exp[$]; // expected stream words, x means any
	logic expLast[$]; // expected end markers
	int failures, checked;
	agd_top u_agd_top (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .adc0Data, .adc1Data, .adcValid,
		.gateIn, .syncIn, .busClkIn, .busSyncIn, .busGateIn, .busClkOut,
		.busSyncOut, .busGateOut, .busOe, .vcxoSel, .dmaData, .dmaValid,
		.dmaLast, .dmaReady);
	agd_host_model u_agd_host_model (.core_clk, .rst_n, .slow, .dmaData,
		.dmaValid, .dmaLast, .dmaReady);
	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : cmp
	// one apb transfer; waits for pready under a bound
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (!pready && n < 50);
		rdata = prdata;
		rerr = pslverr;
		cmp("pready", 32'h1, {31'h0, pready});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] e, input string what);
		apb(1'b0, a, 32'h0);
		cmp(what, e, rdata);
	endtask : rd
	// sample ticks: adcValid in master mode, bus clock rise in slave mode
	task tick(input int n, input logic [15:0] b);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			adc0Data <= b + 16'(i);
			adc1Data <= ~(b + 16'(i));
			if (master) adcValid <= 1'b1;
			else busClkIn <= 1'b1;
			@(posedge core_clk);
			adcValid <= 1'b0;
			busClkIn <= 1'b0;
		end
	endtask : tick
	task ex(input logic [31:0] w, input logic l);
		exp.push_back(w);
		expLast.push_back(l);
	endtask : ex
	// compare what the host took against the expected stream
	task stream;
		int n;
		n = 0;
		while (u_agd_host_model.words.size() < exp.size() && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		repeat (20) @(posedge core_clk);
		cmp("word count", exp.size(), u_agd_host_model.words.size());
		for (int i = 0; i < exp.size(); i++) begin
			if (i < u_agd_host_model.words.size()) begin
				if (!$isunknown(exp[i]))
					cmp("dma word", exp[i], u_agd_host_model.words[i]);
				cmp("dma last", {31'h0, expLast[i]},
					{31'h0, u_agd_host_model.lasts[i]});
			end
		end
		exp.delete();
		expLast.delete();
		u_agd_host_model.words.delete();
		u_agd_host_model.lasts.delete();
	endtask : stream
	// watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		tally_and_finish;
	end
	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, adcValid} = '0;
		{adc0Data, adc1Data, gateIn, syncIn, busClkIn} = '0;
		{busSyncIn, busGateIn, slow, master, failures, checked} = '0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(agd_pkg::OFF_CTRL, 32'h0, "ctrl reset");
		rd(agd_pkg::OFF_SRC, 32'h4, "src reset");
		rd(agd_pkg::OFF_STATUS, 32'h1, "status reset");
		for (int i = 0; i < 4; i++)
			rd(agd_pkg::OFF_LINK0 + 12'(4 * i), 32'h100000, "link reset");
		rd(12'h100, 32'h0, "unmapped read");
		cmp("unmapped error", 32'h1, {31'h0, rerr});
		apb(1'b1, agd_pkg::OFF_SRC, 32'h9);
		rd(agd_pkg::OFF_SRC, 32'h9, "src select");
		// start bit left clear: a run started here would wait for a gate
		apb(1'b1, agd_pkg::OFF_CTRL, 32'hfe);
		rd(agd_pkg::OFF_CTRL, 32'he, "ctrl mask");
		cmp("osc select", 32'h1, {31'h0, vcxoSel});
		cmp("bus drive", 32'h1, {31'h0, busOe});
		apb(1'b1, agd_pkg::OFF_CTRL, 32'h0);
		repeat (3) @(posedge core_clk);
		cmp("direct clock", 32'h0, {31'h0, vcxoSel});
		cmp("bus release", 32'h0, {31'h0, busOe});
		// slave mode chain: two fixed-length links, module 0 on adc1
		apb(1'b1, agd_pkg::OFF_SRC, 32'h1);
		apb(1'b1, agd_pkg::OFF_LINK0, 32'h10002);
		apb(1'b1, agd_pkg::OFF_LINK0 + 12'h4, 32'h180003);
		apb(1'b1, agd_pkg::OFF_CTRL, 32'h1);
		rd(agd_pkg::OFF_CTRL, 32'h0, "start not stored");
		repeat (4) @(posedge core_clk);
		tick(2, 16'h0100);
		repeat (12) @(posedge core_clk);
		tick(3, 16'h0200);
		ex(32'h0000feff, 1'b0);
		ex(32'h0000fefe, 1'b1);
		ex(32'h00050003, 1'b0);
		ex(32'h00000002, 1'b0);
		ex(32'h0000fdff, 1'b0);
		ex(32'h0000fdfe, 1'b0);
		ex(32'h0000fdfd, 1'b1);
		stream;
		apb(1'b0, agd_pkg::OFF_STATUS, 32'h0);
		cmp("status chain", 32'h00030001, rdata & 32'hffff003f);
		// master mode gate driven link on module 1, slow host
		apb(1'b1, agd_pkg::OFF_CTRL, 32'h8);
		master = 1'b1;
		slow <= 1'b1;
		apb(1'b1, agd_pkg::OFF_LINK0, 32'h3c0000);
		apb(1'b1, agd_pkg::OFF_CTRL, 32'h9);
		repeat (4) @(posedge core_clk);
		gateIn <= 2'h3;
		syncIn <= 2'h2;
		tick(5, 16'h0300);
		cmp("bus gate", 32'h3, {30'h0, busGateOut});
		cmp("bus sync", 32'h2, {30'h0, busSyncOut});
		@(posedge core_clk);
		gateIn <= 2'h0;
		syncIn <= 2'h0;
		ex(32'h00080005, 1'b0);
		ex(32'h00000005, 1'b0);
		for (int i = 0; i < 5; i++)
			ex(32'h300 + 32'(i), i == 4);
		stream;
		apb(1'b0, agd_pkg::OFF_STATUS, 32'h0);
		cmp("status gate", 32'h00050001, rdata & 32'hffff003f);
		apb(1'b1, agd_pkg::OFF_CTRL, 32'h0);
		repeat (3) @(posedge core_clk);
		cmp("bus off", 32'h0, {31'h0, busOe});
		// slave mode: local sync ignored, bus sync zeroes the time base
		syncIn <= 2'h1;
		@(posedge core_clk);
		syncIn <= 2'h0;
		rd(agd_pkg::OFF_TSTAMP, 32'ha, "local sync ignored");
		busSyncIn <= 2'h1;
		@(posedge core_clk);
		busSyncIn <= 2'h0;
		rd(agd_pkg::OFF_TSTAMP, 32'h0, "bus sync");
		tally_and_finish;
	end
endmodule : agd_top_test
